// File: core/rxfhs_classify.sv
`timescale 1ns/1ns
module rxfhs_classify
    import rxfhs_pkg::*;
(
    // Completed frame attributes
    input  wire logic [47:0] dest_addr,
    input  wire logic [15:0] len_type,
    input  wire logic [15:0] byte_len,
    input  wire logic        icmp_sum_bad,
    input  wire logic        ip_sum_bad,
    input  wire logic        tcp_sum_bad,
    input  wire logic        udp_sum_bad,
    input  wire logic        mii_err,
    input  wire logic        runt,
    input  wire logic        crc_err,
    input  wire logic        pass_bad_frame,
    // Classified header entry
    output logic      [15:0] status_word,
    output logic      [11:0] byte_field,
    output logic             discard
);
    logic bcast;
    logic mcast;
    logic too_long;
    logic etype;

    assign bcast    = (dest_addr == RXFHS_BCAST_ADDR);
    // The group bit is set in the broadcast address, so it is covered too
    assign mcast    = dest_addr[RXFHS_GROUP_BIT];
    assign too_long = (byte_len > RXFHS_MAX_LEN);
    // Meaningless for runts; software must ignore it then
    assign etype    = (len_type > RXFHS_ETYPE_MIN);

    always_comb begin
        status_word                  = RXFHS_ZERO16;
        // An entry only exists once the frame is complete
        status_word[RXFHS_VALID_BIT] = 1'b1;
        status_word[RXFHS_ICMP_BIT]  = icmp_sum_bad;
        status_word[RXFHS_IPHDR_BIT] = ip_sum_bad;
        status_word[RXFHS_TCP_BIT]   = tcp_sum_bad;
        status_word[RXFHS_UDP_BIT]   = udp_sum_bad;
        status_word[RXFHS_BCAST_BIT] = bcast;
        status_word[RXFHS_MCAST_BIT] = mcast;
        status_word[RXFHS_UCAST_BIT] = ~mcast;
        status_word[RXFHS_MII_BIT]   = mii_err;
        status_word[RXFHS_ETYPE_BIT] = etype;
        status_word[RXFHS_LONG_BIT]  = too_long;
        status_word[RXFHS_RUNT_BIT]  = runt;
        status_word[RXFHS_CRC_BIT]   = crc_err;
    end

    // Long frames are never cut; the count saturates beyond the field
    assign byte_field = (byte_len > RXFHS_BCNT_LIMIT)
                        ? RXFHS_BCNT_SAT : byte_len[11:0];

    assign discard = (runt | crc_err | too_long)
                     & ~pass_bad_frame;

endmodule : rxfhs_classify

// File: core/rxfhs_pkg.sv
package rxfhs_pkg;

    // Register port addresses
    localparam logic [7:0]  RXFHS_STATUS_OFS   = 8'h7C;
    localparam logic [7:0]  RXFHS_BCOUNT_OFS   = 8'h7E;

    // Status word field positions
    localparam int          RXFHS_VALID_BIT    = 15;
    localparam int          RXFHS_ICMP_BIT     = 13;
    localparam int          RXFHS_IPHDR_BIT    = 12;
    localparam int          RXFHS_TCP_BIT      = 11;
    localparam int          RXFHS_UDP_BIT      = 10;
    localparam int          RXFHS_BCAST_BIT    = 7;
    localparam int          RXFHS_MCAST_BIT    = 6;
    localparam int          RXFHS_UCAST_BIT    = 5;
    localparam int          RXFHS_MII_BIT      = 4;
    localparam int          RXFHS_ETYPE_BIT    = 3;
    localparam int          RXFHS_LONG_BIT     = 2;
    localparam int          RXFHS_RUNT_BIT     = 1;
    localparam int          RXFHS_CRC_BIT      = 0;
    localparam int          RXFHS_BCNT_W       = 12;

    // Reserved bit masks, these bits always read as zero
    localparam logic [15:0] RXFHS_STATUS_RSVD  = 16'h4300;
    localparam logic [15:0] RXFHS_BCOUNT_RSVD  = 16'hF000;

    // Frame classification limits
    localparam logic [15:0] RXFHS_ETYPE_MIN    = 16'h05DC;
    localparam logic [15:0] RXFHS_MAX_LEN      = 16'h07D0;
    localparam logic [15:0] RXFHS_BCNT_LIMIT   = 16'h0FFF;
    localparam logic [11:0] RXFHS_BCNT_SAT     = 12'hFFF;
    localparam logic [47:0] RXFHS_BCAST_ADDR   = 48'hFFFF_FFFF_FFFF;
    localparam int          RXFHS_GROUP_BIT    = 40;

    // Header queue geometry
    localparam int          RXFHS_PTR_W        = 2;
    localparam int          RXFHS_CNT_W        = 3;
    localparam int          RXFHS_DEPTH        = 4;
    localparam logic [2:0]  RXFHS_DEPTH_CNT    = 3'h4;
    localparam logic [15:0] RXFHS_ZERO16       = 16'h0000;

    typedef struct packed {
        logic [15:0] status;
        logic [11:0] bytes;
    } rxfhs_entry_t;

endpackage : rxfhs_pkg

// File: core/rxfhs_top.sv
`timescale 1ns/1ns
// Functional notes
// - Valid bit set only for a complete head frame; else clear.
// - Status bit 13 flags a bad ICMP checksum.
// - Status bit 12 flags a bad IP header checksum.
// - Status bit 11 flags a bad TCP checksum.
// - Status bit 10 flags a bad UDP checksum.
// - Status bit 7 flags a broadcast destination.
// - Status bit 6 flags multicast destinations, broadcast included.
// - Status bit 5 flags a unicast destination.
// - Status bit 4 flags an MII symbol error during the frame.
// - Status bit 3 set when length/type exceeds 1500; ignore for runts.
// - Status bit 2 flags frames over 2000 bytes; passed only if allowed.
// - Over-length frames are never truncated; the flag also drops them unless pass-bad is enabled.
// - Status bit 1 flags a runt or collision-damaged frame.
// - Status bit 0 flags a frame check sequence mismatch.
// - Runt and CRC-error frames are queued only with pass-bad enabled.
// - Byte count word bits 11..0 give the head frame size.
// - One entry per counted frame; host reads each byte count at most once.
module rxfhs_top
    import rxfhs_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Receive engine side
    input  wire logic                   rx_start,
    input  wire logic                   frame_end,
    input  wire logic [47:0]            dest_addr,
    input  wire logic [15:0]            len_type,
    input  wire logic [15:0]            byte_len,
    input  wire logic                   icmp_sum_bad,
    input  wire logic                   ip_sum_bad,
    input  wire logic                   tcp_sum_bad,
    input  wire logic                   udp_sum_bad,
    input  wire logic                   mii_err,
    input  wire logic                   runt,
    input  wire logic                   crc_err,
    input  wire logic                   pass_bad_frame,
    // Register read port
    input  wire logic                   rd_en,
    input  wire logic [7:0]             rd_addr,
    output logic      [15:0]            rd_data,
    output logic                        rd_ack,
    // Queue state
    output logic      [RXFHS_CNT_W-1:0] frame_count,
    output logic                        reception_active,
    output logic                        frame_dropped
);
    import rxfhs_pkg::*;

    typedef struct packed {
        rxfhs_entry_t [RXFHS_DEPTH-1:0] q;
        logic [RXFHS_PTR_W-1:0]         wr_ptr;
        logic [RXFHS_PTR_W-1:0]         rd_ptr;
        logic [RXFHS_CNT_W-1:0]         count;
        logic                           busy;
        logic [15:0]                    rd_data;
        logic                           rd_ack;
        logic                           dropped;
    } rxfhs_state_t;

    rxfhs_state_t s_r;
    rxfhs_state_t s_nxt;

    logic [15:0]  cls_status;
    logic [11:0]  cls_bytes;
    logic         cls_discard;
    logic         push;
    logic         pop;
    logic         empty;
    logic         full;
    rxfhs_entry_t head;

    rxfhs_classify u_classify (
        .dest_addr      (dest_addr),
        .len_type       (len_type),
        .byte_len       (byte_len),
        .icmp_sum_bad   (icmp_sum_bad),
        .ip_sum_bad     (ip_sum_bad),
        .tcp_sum_bad    (tcp_sum_bad),
        .udp_sum_bad    (udp_sum_bad),
        .mii_err        (mii_err),
        .runt           (runt),
        .crc_err        (crc_err),
        .pass_bad_frame (pass_bad_frame),
        .status_word    (cls_status),
        .byte_field     (cls_bytes),
        .discard        (cls_discard)
    );

    assign empty = (s_r.count == '0);
    assign full  = (s_r.count == RXFHS_DEPTH_CNT);
    assign head  = s_r.q[s_r.rd_ptr];

    // Full check uses the current count: a pop in the same cycle does not
    // make room, which keeps the queue logic free of a combinational loop
    assign push = frame_end & ~cls_discard & ~full;
    // Reading the byte count retires the head entry
    assign pop  = rd_en & (rd_addr == RXFHS_BCOUNT_OFS) & ~empty;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.rd_ack  = 1'b0;
        s_nxt.dropped = 1'b0;

        if (rx_start) begin
            s_nxt.busy = 1'b1;
        end
        if (frame_end) begin
            s_nxt.busy = 1'b0;
        end

        if (push) begin
            s_nxt.q[s_r.wr_ptr].status = cls_status;
            s_nxt.q[s_r.wr_ptr].bytes  = cls_bytes;
            s_nxt.wr_ptr               = s_r.wr_ptr + 2'h1;
        end
        if (frame_end & ~cls_discard & full) begin
            s_nxt.dropped = 1'b1;
        end
        if (pop) begin
            s_nxt.rd_ptr = s_r.rd_ptr + 2'h1;
        end

        case ({push, pop})
            2'b10: begin
                s_nxt.count = s_r.count + 3'h1;
            end
            2'b01: begin
                s_nxt.count = s_r.count - 3'h1;
            end
            default: begin
                s_nxt.count = s_r.count;
            end
        endcase

        if (rd_en) begin
            s_nxt.rd_ack  = 1'b1;
            s_nxt.rd_data = RXFHS_ZERO16;
            case (rd_addr)
                RXFHS_STATUS_OFS: begin
                    // No entry means nothing complete: valid reads clear
                    if (!empty) begin
                        s_nxt.rd_data = head.status
                                    & ~RXFHS_STATUS_RSVD;
                    end
                end
                RXFHS_BCOUNT_OFS: begin
                    if (!empty) begin
                        s_nxt.rd_data = {4'h0, head.bytes};
                    end
                end
                default: begin
                    s_nxt.rd_data = RXFHS_ZERO16;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data          = s_r.rd_data;
    assign rd_ack           = s_r.rd_ack;
    assign frame_count      = s_r.count;
    assign reception_active = s_r.busy;
    assign frame_dropped    = s_r.dropped;

    property p_valid_empty;
        @(posedge clk) disable iff (rst)
        (rd_en && rd_addr == RXFHS_STATUS_OFS && empty)
            |=> (rd_ack && !rd_data[RXFHS_VALID_BIT]);
    endproperty
    a_valid_empty: assert property (p_valid_empty)
        else $error("valid bit set with no pending frame");

    property p_valid_full;
        @(posedge clk) disable iff (rst)
        (rd_en && rd_addr == RXFHS_STATUS_OFS && !empty)
            |=> rd_data[RXFHS_VALID_BIT];
    endproperty
    a_valid_full: assert property (p_valid_full)
        else $error("valid bit clear with a pending frame");

    property p_rsvd_status;
        @(posedge clk) disable iff (rst)
        (rd_en && rd_addr == RXFHS_STATUS_OFS)
            |=> ((rd_data & RXFHS_STATUS_RSVD) == RXFHS_ZERO16);
    endproperty
    a_rsvd_status: assert property (p_rsvd_status)
        else $error("reserved status bits not zero");

    property p_bytes_read;
        @(posedge clk) disable iff (rst)
        (rd_en && rd_addr == RXFHS_BCOUNT_OFS && !empty)
            |=> (rd_data == {4'h0, $past(head.bytes)});
    endproperty
    a_bytes_read: assert property (p_bytes_read)
        else $error("byte count word differs from head entry");

    property p_discard_bad;
        @(posedge clk) disable iff (rst)
        (frame_end && (runt || crc_err) && !pass_bad_frame && !pop)
            |=> $stable(s_r.count);
    endproperty
    a_discard_bad: assert property (p_discard_bad)
        else $error("bad frame queued while pass-bad disabled");

    property p_push_count;
        @(posedge clk) disable iff (rst)
        (frame_end && !cls_discard && !full && !pop)
            |=> (s_r.count == $past(s_r.count) + 3'h1);
    endproperty
    a_push_count: assert property (p_push_count)
        else $error("accepted frame did not add one entry");

    property p_pop_count;
        @(posedge clk) disable iff (rst)
        (pop && !push) |=> (s_r.count == $past(s_r.count) - 3'h1);
    endproperty
    a_pop_count: assert property (p_pop_count)
        else $error("byte count read did not retire one entry");

    property p_bcast_mcast;
        @(posedge clk) disable iff (rst)
        (frame_end && dest_addr == RXFHS_BCAST_ADDR)
            |-> (cls_status[RXFHS_BCAST_BIT] && cls_status[RXFHS_MCAST_BIT]
                 && !cls_status[RXFHS_UCAST_BIT]);
    endproperty
    a_bcast_mcast: assert property (p_bcast_mcast)
        else $error("broadcast frame not also marked multicast");

    property p_ethertype;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_ETYPE_BIT]
                       == (len_type > RXFHS_ETYPE_MIN));
    endproperty
    a_ethertype: assert property (p_ethertype)
        else $error("frame type bit wrong for length/type field");

    property p_too_long;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_LONG_BIT]
                       == (byte_len > RXFHS_MAX_LEN));
    endproperty
    a_too_long: assert property (p_too_long)
        else $error("too-long bit wrong for frame length");

    property p_crc;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_CRC_BIT] == crc_err
                       && cls_status[RXFHS_RUNT_BIT] == runt);
    endproperty
    a_crc: assert property (p_crc)
        else $error("crc or runt bit does not follow the frame");

    property p_stored_status;
        @(posedge clk) disable iff (rst)
        (push && empty && !pop) ##1 !pop
            ##1 (rd_en && rd_addr == RXFHS_STATUS_OFS)
            |=> (rd_data == ($past(cls_status, 3) & ~RXFHS_STATUS_RSVD));
    endproperty
    a_stored_status: assert property (p_stored_status)
        else $error("stored status differs from classified frame");

    property p_sum_bits;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_ICMP_BIT] == icmp_sum_bad
                       && cls_status[RXFHS_IPHDR_BIT] == ip_sum_bad);
    endproperty
    a_sum_bits: assert property (p_sum_bits)
        else $error("icmp or ip checksum bit does not follow the frame");

    property p_l4_bits;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_TCP_BIT] == tcp_sum_bad
                       && cls_status[RXFHS_UDP_BIT] == udp_sum_bad);
    endproperty
    a_l4_bits: assert property (p_l4_bits)
        else $error("tcp or udp checksum bit does not follow the frame");

    property p_mii_ucast;
        @(posedge clk) disable iff (rst)
        frame_end |-> (cls_status[RXFHS_MII_BIT] == mii_err
                       && cls_status[RXFHS_UCAST_BIT]
                          == !dest_addr[RXFHS_GROUP_BIT]);
    endproperty
    a_mii_ucast: assert property (p_mii_ucast)
        else $error("mii error or unicast bit does not follow the frame");

    property p_rsvd_bcount;
        @(posedge clk) disable iff (rst)
        (rd_en && rd_addr == RXFHS_BCOUNT_OFS)
            |=> ((rd_data & RXFHS_BCOUNT_RSVD) == RXFHS_ZERO16);
    endproperty
    a_rsvd_bcount: assert property (p_rsvd_bcount)
        else $error("reserved byte count bits not zero");

    property p_full_drop;
        @(posedge clk) disable iff (rst)
        (frame_end && !cls_discard && full) |=> frame_dropped;
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("frame lost on a full queue without a drop pulse");

    property p_busy_clear;
        @(posedge clk) disable iff (rst)
        frame_end |=> !reception_active;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("reception still shown active after frame end");

endmodule : rxfhs_top

// File: test/rx_frame_header_status_tb.sv
`timescale 1ns/1ns
module rx_frame_header_status_tb;
    import rxfhs_pkg::*;
    typedef struct packed {
        logic [47:0] da;
        logic [15:0] lt;
        logic [15:0] bl;
        logic [6:0]  fl;
        logic        pb;
        logic [15:0] st;
        logic [11:0] bc;
    } rxfhs_row_t;
    // Error flags: icmp, ip, tcp, udp, mii, runt, crc
    rxfhs_row_t tbl [7] = '{
    '{48'hFFFF_FFFF_FFFF, 16'h0800, 16'h0040, 7'h00, 1'b0, 16'h80C8, 12'h040},
    '{48'h0011_2233_4455, 16'h0100, 16'h05DC, 7'h40, 1'b0, 16'hA020, 12'h5DC},
    '{48'h0100_5E00_0001, 16'h05DC, 16'h0100, 7'h30, 1'b0, 16'h9840, 12'h100},
    '{48'h0011_2233_4455, 16'h05DD, 16'h003C, 7'h0C, 1'b0, 16'h8438, 12'h03C},
    '{48'h0011_2233_4455, 16'h0800, 16'h07D1, 7'h03, 1'b1, 16'h802F, 12'h7D1},
    '{48'h0011_2233_4455, 16'h0800, 16'h07D0, 7'h00, 1'b0, 16'h8028, 12'h7D0},
    '{48'h0011_2233_4455, 16'h0800, 16'h1234, 7'h00, 1'b1, 16'h802C, 12'hFFF}
    };
    logic        clk, rst, rx_start, frame_end, pass_bad_frame;
    logic [47:0] dest_addr;
    logic [15:0] len_type, byte_len, rd_data;
    logic        icmp_sum_bad, ip_sum_bad, tcp_sum_bad, udp_sum_bad;
    logic        mii_err, runt, crc_err, rd_en, rd_ack;
    logic [7:0]  rd_addr;
    logic [2:0]  frame_count;
    logic        reception_active, frame_dropped;
    int          n_mismatch, n_checks;
    rxfhs_row_t  r;

    rxfhs_top dut_u (.clk(clk), .rst(rst), .rx_start(rx_start),
        .frame_end(frame_end), .dest_addr(dest_addr), .len_type(len_type),
        .byte_len(byte_len), .icmp_sum_bad(icmp_sum_bad),
        .ip_sum_bad(ip_sum_bad), .tcp_sum_bad(tcp_sum_bad),
        .udp_sum_bad(udp_sum_bad), .mii_err(mii_err), .runt(runt),
        .crc_err(crc_err), .pass_bad_frame(pass_bad_frame), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack),
        .frame_count(frame_count), .reception_active(reception_active),
        .frame_dropped(frame_dropped));
    rxfhs_host host_u (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_ack(rd_ack));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    task automatic rdchk(logic [7:0] a, logic [15:0] e, string nm);
        logic [15:0] d;
        logic        ok;
        host_u.rd(a, d, ok);
        if (!ok) begin
            $display("[FAIL] %s expected ack seen none", nm);
            n_mismatch++;
            give_verdict();
        end else begin
            chk(nm, e, d);
        end
    endtask : rdchk

    // Attributes stay put after the pulse; the design samples them only
    // on the rising clock edge while frame_end is high
    task automatic frame(rxfhs_row_t f);
        @(negedge clk);
        {dest_addr, len_type, byte_len} = {f.da, f.lt, f.bl};
        {icmp_sum_bad, ip_sum_bad, tcp_sum_bad, udp_sum_bad} = f.fl[6:3];
        {mii_err, runt, crc_err, pass_bad_frame} = {f.fl[2:0], f.pb};
        frame_end = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
    endtask : frame

    task automatic cnt(logic [2:0] e);
        chk("frame_count", {13'h0000, e}, {13'h0000, frame_count});
    endtask : cnt

    initial begin
        n_mismatch = 0;
        n_checks   = 0;
        {rst, rx_start, frame_end} = 3'b100;
        r = tbl[0];
        frame_end = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        cnt(3'h0);
        chk("reset outputs", 16'h0000, {rd_data[15:3], rd_ack,
            reception_active, frame_dropped});
        for (int i = 0; i < 7; i++) begin
            frame(tbl[i]);
            cnt(3'h1);
            rdchk(RXFHS_STATUS_OFS, tbl[i].st, "status");
            rdchk(RXFHS_STATUS_OFS, tbl[i].st, "status again");
            rdchk(RXFHS_BCOUNT_OFS, {4'h0, tbl[i].bc}, "bytes");
            cnt(3'h0);
        end
        rdchk(RXFHS_STATUS_OFS, 16'h0000, "empty status");
        rdchk(RXFHS_BCOUNT_OFS, 16'h0000, "empty bytes");
        rdchk(8'h7A, 16'h0000, "unmapped");
        @(negedge clk);
        rx_start = 1'b1;
        @(negedge clk);
        rx_start = 1'b0;
        chk("active", 16'h0001, {15'h0000, reception_active});
        rdchk(RXFHS_STATUS_OFS, 16'h0000, "busy status");
        frame(tbl[0]);
        chk("idle", 16'h0000, {15'h0000, reception_active});
        rdchk(RXFHS_BCOUNT_OFS, {4'h0, tbl[0].bc}, "bytes");
        for (int i = 0; i < 3; i++) begin
            r = tbl[0];
            r.fl = (i == 0) ? 7'h02 : (i == 1) ? 7'h01 : 7'h00;
            r.bl = (i == 2) ? 16'h07D1 : r.bl;
            frame(r);
            chk("dropped", 16'h0000, {15'h0000, frame_dropped});
            cnt(3'h0);
        end
        for (int i = 0; i < 5; i++) begin
            frame(tbl[i]);
            chk("full drop", {15'h0000, i == 4},
                {15'h0000, frame_dropped});
        end
        cnt(3'h4);
        for (int i = 0; i < 4; i++) begin
            rdchk(RXFHS_STATUS_OFS, tbl[i].st, "fifo status");
            rdchk(RXFHS_BCOUNT_OFS, {4'h0, tbl[i].bc},
                  "fifo bytes");
            cnt(3'(3 - i));
        end
        frame(tbl[1]);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        cnt(3'h0);
        rdchk(RXFHS_STATUS_OFS, 16'h0000, "after reset");
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        $display("[FAIL] run expected end seen hang");
        n_mismatch++;
        give_verdict();
    end
endmodule : rx_frame_header_status_tb

// File: test/rxfhs_host.sv
`timescale 1ns/1ns
module rxfhs_host (
    // Clock
    input  wire logic        clk,
    // Register read port
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_ack
);
    initial begin
        rd_en   = 1'b0;
        rd_addr = 8'h00;
    end

    // One read; the address is scrambled after release so a stale
    // address can never be mistaken for a held request
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
        ok = 1'b0;
        d  = 16'h0000;
        @(negedge clk);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en   = 1'b0;
        rd_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_ack === 1'b1) begin
                ok = 1'b1;
                d  = rd_data;
            end else begin
                @(negedge clk);
            end
        end
    endtask : rd
endmodule : rxfhs_host
